// file: core/tsi_irq_unit.sv
// Notes on behaviour
// - three sources: external pin, timer overflow, upper port b change
// - one control register holds flags, per-source enables and global enable
// - global enable at bit 7 gates every source
// - clear individual enable blocks that source only
// - reset clears the global enable
// - on accept: clear global enable, push return, load pc 0004h
// - pin events serviced three or four cycles later, any instruction
// - flags set regardless of individual or global enables
// - instruction clearing global enable makes next cycle a nop, no irq
// - suppressed requests stay pending until global enable returns
// - return instruction pops stack into pc, sets global enable, two cycles
`timescale 1ns/100ps
module tsi_irq_unit
    import tsi_pkg::*;
(
    // clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // pins
    input  wire logic                ext_irq_pin,
    input  wire logic [3:0]          port_b_upper_nibble,
    // timer and core
    input  wire logic                main_timer_ovf,
    input  wire logic                instr_cycle_en,
    input  wire logic                core_gie_clear,
    input  wire logic                core_gie_set,
    input  wire logic                return_from_irq_instr,
    output tsi_pkg::tsi_core_req_t   core_req,
    output logic                     irq_req,
    output logic                     irq
);
    import tsi_pkg::*;

    logic [7:0]         irq_control_reg_q;
    logic [TSI_NEV-1:0] ev_stat_q;
    logic [TSI_NEV-1:0] ev_mask_q;
    tsi_state_t         state_q;
    logic [1:0]         ret_cnt_q;
    logic               ext_s;
    logic [3:0]         pb_s;
    logic               ext_prev_q;
    logic [3:0]         pb_prev_q;
    logic [3:0]         port_b_latch_q;
    logic [2:0]         ev_src;
    logic               wr_en;
    logic               rd_en;
    logic               ctrl_wr;
    logic               take;
    logic               pending;
    logic               global_irq_enable;
    logic [TSI_NEV-1:0] ev_now;

    // pin inputs come from another domain
    tsi_sync #(.W(5)) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in ({ext_irq_pin, port_b_upper_nibble}),
        .sync_out ({ext_s, pb_s})
    );

    // edge and change detection on qualified pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_q <= 1'b0;
            pb_prev_q  <= 4'h0;
        end else begin
            ext_prev_q <= ext_s;
            pb_prev_q  <= pb_s;
        end
    end

    // source events, seen every pclk so none is missed between cycles
    always_comb begin
        ev_src                = '0;
        ev_src[TSI_BIT_TFLAG] = main_timer_ovf;
        ev_src[TSI_BIT_EFLAG] = ext_s & ~ext_prev_q;
        ev_src[TSI_BIT_PFLAG] = |(pb_s ^ port_b_latch_q);
    end

    // apb decode, zero wait states
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & penable & ~pwrite;
    assign pready  = 1'b1;
    assign ctrl_wr = wr_en && (paddr == TSI_OFF_CTRL);

    always_comb begin
        pslverr = 1'b0;
        if (psel && penable) begin
            case (paddr)
                TSI_OFF_CTRL, TSI_OFF_STAT, TSI_OFF_MASK: pslverr = 1'b0;
                TSI_OFF_PORT_B_PINS: pslverr = pwrite; // read only
                default: pslverr = 1'b1;
            endcase
        end
    end

    // read data registered; a read takes the value of the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                TSI_OFF_CTRL:  prdata <= {24'h00_0000, irq_control_reg_q};
                TSI_OFF_STAT:  prdata <= {29'h0, ev_stat_q};
                TSI_OFF_MASK:  prdata <= {29'h0, ev_mask_q};
                TSI_OFF_PORT_B_PINS: prdata <= {28'h000_0000, port_b_latch_q};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    assign global_irq_enable = irq_control_reg_q[TSI_BIT_GIE];

    // pending when a flag and its enable are both set
    assign pending = |(irq_control_reg_q[TSI_BIT_PFLAG:TSI_BIT_TFLAG]
                     & irq_control_reg_q[TSI_BIT_PEN:TSI_BIT_TEN]);
    assign irq_req = global_irq_enable & pending;

    // accept only in a normal instruction slot; nop slot blocks it
    assign take = irq_req && instr_cycle_en && (state_q == TSI_RUN)
                  && !core_gie_clear;

    // port b reference: latched when software reads the control register,
    // so a mismatch holds the change until the control register is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_b_latch_q <= 4'h0;
        end else if (rd_en && paddr == TSI_OFF_CTRL) begin
            port_b_latch_q <= pb_s;
        end
    end

    // control register: flags, enables, global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_control_reg_q <= TSI_CTRL_RST;
        end else begin
            if (ctrl_wr) begin
                irq_control_reg_q <= pwdata[7:0];
            end
            // set wins over software clear
            for (int i = 0; i < TSI_NSRC; i++) begin
                if (ev_src[i]) begin
                    irq_control_reg_q[i] <= 1'b1;
                end
            end
            // global enable control from the core sequencer
            if (take || core_gie_clear) begin
                irq_control_reg_q[TSI_BIT_GIE] <= 1'b0;
            end else if (core_gie_set ||
                         (state_q == TSI_RET_WAIT && ret_cnt_q == 2'd0
                          && instr_cycle_en)) begin
                irq_control_reg_q[TSI_BIT_GIE] <= 1'b1;
            end
        end
    end

    // sequencer: nop slot after a global clear, two-cycle return
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= TSI_RUN;
            ret_cnt_q <= 2'd0;
        end else if (instr_cycle_en) begin
            case (state_q)
                TSI_RUN: begin
                    if (core_gie_clear) begin
                        state_q <= TSI_NOP_SLOT;
                    end else if (return_from_irq_instr && !take) begin
                        state_q   <= TSI_RET_WAIT;
                        ret_cnt_q <= 2'(TSI_RET_CYC - 2);
                    end
                end
                TSI_NOP_SLOT: state_q <= TSI_RUN;
                TSI_RET_WAIT: begin
                    if (ret_cnt_q == 2'd0) begin
                        state_q <= TSI_RUN;
                    end else begin
                        ret_cnt_q <= ret_cnt_q - 2'd1;
                    end
                end
                default: state_q <= TSI_RUN;
            endcase
        end
    end

    // pulses to the core; handshake outputs are combinational
    always_comb begin
        core_req        = '0;
        core_req.vector = TSI_VECTOR;
        core_req.take   = take;
        core_req.push   = take;
        core_req.pop    = instr_cycle_en && state_q == TSI_RUN
                          && return_from_irq_instr && !take;
        core_req.nop    = instr_cycle_en && state_q == TSI_NOP_SLOT;
    end

    // event status and interrupt
    always_comb begin
        ev_now                 = '0;
        ev_now[TSI_EV_TAKEN]   = take;
        ev_now[TSI_EV_RETURN]  = core_req.pop;
        ev_now[TSI_EV_BLOCKED] = core_req.nop && irq_req;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_stat_q <= '0;
            ev_mask_q <= '0;
        end else begin
            if (wr_en && paddr == TSI_OFF_MASK) begin
                ev_mask_q <= pwdata[TSI_NEV-1:0];
            end
            // write one to clear, set wins
            ev_stat_q <= (ev_stat_q &
                          ~((wr_en && paddr == TSI_OFF_STAT)
                            ? pwdata[TSI_NEV-1:0] : '0)) | ev_now;
        end
    end

    assign irq = |(ev_stat_q & ev_mask_q);

endmodule // tsi_irq_unit

// file: core/tsi_pkg.sv
package tsi_pkg;

    // apb register byte offsets
    localparam logic [7:0] TSI_OFF_CTRL   = 8'h00; // irq control register
    localparam logic [7:0] TSI_OFF_STAT   = 8'h04; // sticky event status
    localparam logic [7:0] TSI_OFF_MASK   = 8'h08; // event mask
    localparam logic [7:0] TSI_OFF_PORT_B_PINS  = 8'h0c; // port b reference latched at control read

    // irq control register fields
    localparam int TSI_NSRC       = 3;
    localparam int TSI_BIT_TFLAG  = 0; // timer overflow flag
    localparam int TSI_BIT_EFLAG  = 1; // external pin flag
    localparam int TSI_BIT_PFLAG  = 2; // port change flag
    localparam int TSI_BIT_TEN    = 3;
    localparam int TSI_BIT_EEN    = 4;
    localparam int TSI_BIT_PEN    = 5;
    localparam int TSI_BIT_GIE    = 7;
    localparam logic [7:0] TSI_CTRL_RST = 8'h00;

    // event status bits
    localparam int TSI_EV_TAKEN   = 0; // vector taken
    localparam int TSI_EV_RETURN  = 1; // return instruction done
    localparam int TSI_EV_BLOCKED = 2; // request suppressed by nop slot
    localparam int TSI_NEV        = 3;

    // vector address and core timing
    localparam logic [12:0] TSI_VECTOR   = 13'h0004;
    localparam int          TSI_RET_CYC  = 2;
    localparam int          TSI_SYNC_LEN = 3;

    // request to the core
    typedef struct packed {
        logic        take;   // pulse: vector now
        logic [12:0] vector; // new program counter
        logic        push;   // pulse: push return address
        logic        pop;    // pulse: pop top of stack into pc
        logic        nop;    // pulse: run a nop this cycle
    } tsi_core_req_t;

    typedef enum logic [1:0] {
        TSI_RUN,
        TSI_NOP_SLOT,
        TSI_RET_WAIT
    } tsi_state_t;

endpackage

// file: core/tsi_sync.sv
`timescale 1ns/100ps
// three flop synchroniser; change counts once stage two and three agree
module tsi_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // async in, qualified out
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    // s1 feeds s2 only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q     <= '0;
            s2_q     <= '0;
            s3_q     <= '0;
            sync_out <= '0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // per-bit agreement filter
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    sync_out[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // tsi_sync

// file: testbench/tsi_irq_unit_monitor.sv
`timescale 1ns/100ps
module tsi_irq_unit_monitor
    import tsi_pkg::*;
(
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // core side
    input wire logic                   instr_cycle_en,
    input wire logic                   core_gie_clear,
    input wire logic                   return_from_irq_instr,
    input wire tsi_pkg::tsi_core_req_t core_req,
    input wire logic                   irq_req
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // vector and push travel together
    vec_value_a: assert property (
        core_req.take |-> core_req.vector == TSI_VECTOR) else $error("vector");
    take_push_a: assert property (
        (core_req.take || core_req.push) |-> (core_req.take && core_req.push))
        else $error("take without push");
    take_cause_a: assert property (
        core_req.take |-> instr_cycle_en && irq_req && !core_gie_clear)
        else $error("take without cause");
    gie_drop_a: assert property (
        core_req.take |=> !irq_req) else $error("enable kept after take");
    nop_slot_a: assert property (
        core_req.nop |-> !core_req.take) else $error("take in nop slot");
    clr_nop_a: assert property (
        instr_cycle_en && core_gie_clear |-> ##[1:8] core_req.nop)
        else $error("no nop after clear");
    pop_cause_a: assert property (
        core_req.pop |-> instr_cycle_en && return_from_irq_instr)
        else $error("pop without return");
    // reset must hold irq_req and take low, so no disable here
    rst_quiet_a: assert property (disable iff (1'b0)
        !presetn |-> !irq_req && !core_req.take) else $error("busy in reset");
    take_c: cover property (core_req.take);
    pop_c: cover property (core_req.pop);
    nop_c: cover property (core_req.nop);
endmodule // tsi_irq_unit_monitor

bind tsi_irq_unit tsi_irq_unit_monitor u_tsi_irq_unit_monitor (
    .pclk(pclk), .presetn(presetn), .instr_cycle_en(instr_cycle_en),
    .core_gie_clear(core_gie_clear), .core_req(core_req), .irq_req(irq_req),
    .return_from_irq_instr(return_from_irq_instr));

// file: testbench/tsi_core_model.sv
`timescale 1ns/100ps
module tsi_core_model
    import tsi_pkg::*;
#(
    parameter int EN_DIV = 4
) (
    // clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // bench command: 1 return, 2 set enable, 3 clear enable
    input wire logic                   cmd_vld,
    input wire logic [1:0]             cmd,
    // unit side
    input wire tsi_pkg::tsi_core_req_t core_req,
    output logic                       instr_cycle_en,
    output logic                       core_gie_clear,
    output logic                       core_gie_set,
    output logic                       return_from_irq_instr,
    // observation
    output logic [12:0]                pc_q,
    output logic [7:0]                 take_cnt_q,
    output logic [7:0]                 nop_cnt_q
);
    logic [3:0]  div_q;
    logic [1:0]  act_q;
    logic [12:0] stack_q;
    // instruction cycle divider
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) div_q <= 4'h0;
        else div_q <= (div_q == 4'(EN_DIV - 1)) ? 4'h0 : div_q + 4'h1;
    end
    assign instr_cycle_en = (div_q == 4'h0);
    // one instruction per command; a command lasts one instruction cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) act_q <= 2'h0;
        else if (cmd_vld) act_q <= cmd;
        else if (instr_cycle_en) act_q <= 2'h0;
    end
    assign return_from_irq_instr = (act_q == 2'h1);
    assign core_gie_set = instr_cycle_en && (act_q == 2'h2);
    assign core_gie_clear = instr_cycle_en && (act_q == 2'h3);
    // program counter with a one deep stack
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pc_q <= 13'h0000;
            stack_q <= 13'h0000;
        end else if (core_req.take) begin
            stack_q <= pc_q + 13'h0001;
            pc_q <= core_req.vector;
        end else if (core_req.pop) pc_q <= stack_q;
        // pc only advances while a commanded instruction runs, so the
        // vector stays visible until the bench looks at it
        else if (instr_cycle_en && act_q != 2'h0) pc_q <= pc_q + 13'h0001;
    end
    // event counters
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            take_cnt_q <= 8'h00;
            nop_cnt_q <= 8'h00;
        end else begin
            take_cnt_q <= take_cnt_q + 8'(core_req.take);
            nop_cnt_q <= nop_cnt_q + 8'(core_req.nop);
        end
    end
endmodule // tsi_core_model

// file: testbench/tsi_irq_unit_tb.sv
`timescale 1ns/100ps
module tsi_irq_unit_tb;
    import tsi_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd_q;
    logic pready, pslverr, err_q, ext = 0, ovf = 0, cmd_vld = 0;
    logic [3:0] nib = 4'h0;
    logic [1:0] cmd = 2'h0;
    logic en, gclr, gset, ret, irq_req, irq;
    logic [12:0] pc;
    logic [7:0] takes, nops;
    tsi_core_req_t req;
    int error_cnt = 0, tests_run = 0;
    tsi_irq_unit u_tsi_irq_unit (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_irq_pin(ext), .port_b_upper_nibble(nib), .main_timer_ovf(ovf),
        .instr_cycle_en(en), .core_gie_clear(gclr), .core_gie_set(gset),
        .return_from_irq_instr(ret), .core_req(req), .irq_req(irq_req),
        .irq(irq));
    tsi_core_model #(.EN_DIV(4)) u_tsi_core_model (.pclk(pclk),
        .presetn(presetn), .cmd_vld(cmd_vld), .cmd(cmd), .core_req(req),
        .instr_cycle_en(en), .core_gie_clear(gclr), .core_gie_set(gset),
        .return_from_irq_instr(ret), .pc_q(pc), .take_cnt_q(takes),
        .nop_cnt_q(nops));
    always #4 pclk = ~pclk;
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    // held until pready is seen high at a rising edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // one idle edge, so a following call never re-drives psel in this step
        @(posedge pclk);
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task rd(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_q, {24'h0, exp});
    endtask
    task core_cmd(input logic [1:0] c);
        cmd <= c; cmd_vld <= 1'b1;
        @(posedge pclk);
        cmd_vld <= 1'b0;
        repeat (16) @(posedge pclk);
    endtask
    task finish_test;
        if (error_cnt == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(TSI_OFF_CTRL, 8'h00);
        rd(8'h10, 8'h00);
        chk(err_q, 1'b1);
        // each source flags with every enable off
        for (int i = 0; i < TSI_NSRC; i++) begin
            wr(TSI_OFF_CTRL, 8'h00);
            rd(TSI_OFF_CTRL, 8'h00);
            if (i == 0) ovf <= 1'b1;
            if (i == 1) ext <= 1'b1;
            if (i == 2) nib <= 4'h4;
            @(posedge pclk);
            ovf <= 1'b0;
            repeat (8) @(posedge pclk);
            rd(TSI_OFF_CTRL, 8'h01 << i);
        end
        wr(TSI_OFF_CTRL, 8'h88);
        ext <= 1'b0;
        repeat (8) @(posedge pclk);
        ext <= 1'b1;
        repeat (8) @(posedge pclk);
        rd(TSI_OFF_CTRL, 8'h8a);
        chk(irq_req, 1'b0);
        ovf <= 1'b1;
        @(posedge pclk);
        ovf <= 1'b0;
        repeat (12) @(posedge pclk);
        chk(takes, 8'h01);
        chk(pc, 13'h0004);
        rd(TSI_OFF_CTRL, 8'h0b);
        rd(TSI_OFF_STAT, 8'h01);
        wr(TSI_OFF_MASK, 8'h01);
        @(negedge pclk) chk(irq, 1'b1);
        @(posedge pclk) wr(TSI_OFF_STAT, 8'h07);
        @(negedge pclk) chk(irq, 1'b0);
        @(posedge pclk) wr(TSI_OFF_CTRL, 8'h08);
        core_cmd(2'h1);
        rd(TSI_OFF_CTRL, 8'h88);
        chk(takes, 8'h01);
        // pending flag, enable set then cleared at once
        wr(TSI_OFF_CTRL, 8'h08);
        ovf <= 1'b1;
        @(posedge pclk);
        ovf <= 1'b0;
        cmd <= 2'h2; cmd_vld <= 1'b1;
        @(posedge pclk);
        cmd_vld <= 1'b0;
        for (int n = 0; n < 20 && gset !== 1'b1; n++) @(negedge pclk);
        @(posedge pclk);
        core_cmd(2'h3);
        chk(takes, 8'h01);
        chk(nops, 8'h01);
        rd(TSI_OFF_CTRL, 8'h09);
        core_cmd(2'h2);
        chk(takes, 8'h02);
        finish_test;
    end
    // watchdog well beyond the few hundred cycles of the sequence
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        finish_test;
    end
endmodule // tsi_irq_unit_tb
